/* File: ebs_sequencer.sv */
// ebs_sequencer: external bus cycle sequencer, one cycle at a time
// assumes requester holds request until done pulse; ready pin is asynchronous or synchronous
//
// Function
// - every bus cycle walks address, C, D, E, F phases in that order, skipping any phase of zero length
// - each phase length programmable per chip select within fixed ranges
// - external ready handshake may stretch the access phase
// - waitstates keep bus pin transitions at least 12.5 ns apart
// - bus reference clock has a period of one system clock
// - read data captured on the edge ending the read strobe
// - demux address may change only after read strobe ends, when the next cycle starts
// - mux drives address then data on shared lines; demux uses separate lines
// - drive read strobe, byte write strobes, byte high enable, latch strobe, selects
// - ready input polarity is selectable
// - asynchronous ready gets three extra synchroniser stages, one waitstate at least
// - ready inactive inserts a waitstate, active ends the access phase
`timescale 1ns/100ps
module ebs_sequencer #(
    parameter int unsigned NUM_CS   = 4,
    parameter int unsigned UNIT_CYC = ebs_pkg::MIN_TRANS_CYC
) (
    input  wire logic                      clk,                // system clock
    input  wire logic                      resetn,             // sync reset, active low
    input  wire logic                      req,                // start a bus cycle, level
    input  wire logic                      req_write,          // 1 write, 0 read
    input  wire logic [1:0]                req_byte_en,        // byte enables, bit1 high byte
    input  wire logic [23:0]               req_addr,           // byte address
    input  wire logic [15:0]               req_wdata,          // write data
    input  wire logic [$clog2(NUM_CS)-1:0] req_cs,             // chip select index
    output logic                           done,               // cycle finished pulse
    output logic [15:0]                    rdata,              // captured read data
    input  wire logic [NUM_CS*ebs_pkg::CFG_WIDTH-1:0] phase_cfg, // per select phase timing
    input  wire logic                      multiplexed_mode,   // 1 mux, 0 demux
    input  wire logic                      ready_en,           // access ends by ready
    input  wire logic                      ready_active_high,  // ready polarity
    input  wire logic                      ready_async,        // ready is asynchronous
    output logic                           bus_reference_clock,// system clock copy
    output logic [23:0]                    address_lines,      // demux address
    output logic [15:0]                    shared_addr_data_o, // mux lines out
    output logic                           shared_addr_data_oe,// mux lines enable
    input  wire logic [15:0]               shared_addr_data_i, // mux lines in
    output logic [15:0]                    separate_data_o,    // demux data out
    output logic                           separate_data_oe,   // demux data enable
    input  wire logic [15:0]               separate_data_i,    // demux data in
    output logic                           read_strobe_n,      // read strobe
    output logic                           write_low_n,        // low byte write strobe
    output logic                           write_high_n,       // high byte write strobe
    output logic                           byte_high_enable_n, // high byte enable
    output logic                           addr_latch,         // address latch strobe
    output logic [NUM_CS-1:0]              chip_select_n,      // chip selects
    input  wire logic                      ready_pin           // external ready
);
    // select index needs at least one bit, unit counter holds up to 64
    if (NUM_CS < 2 || UNIT_CYC < 1 || UNIT_CYC > 64) begin : g_bad_params
        $error("ebs_sequencer: bad parameters");
    end

    assign bus_reference_clock = clk;

    logic [2:0] rdy_sync;
    logic       rdy_sync_lvl;
    logic       rdy_raw;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdy_sync     <= 3'h0;
            rdy_raw      <= 1'b0;
            rdy_sync_lvl <= 1'b0;
        end else begin
            rdy_sync     <= {rdy_sync[1:0], ready_pin};
            rdy_raw      <= ready_pin;
            rdy_sync_lvl <= (rdy_sync[2] == rdy_sync[1]) ? rdy_sync[2] : rdy_sync_lvl;
        end
    end
    logic rdy_level;
    logic rdy_seen;
    assign rdy_level = ready_async ? rdy_sync_lvl : rdy_raw;
    assign rdy_seen = ready_active_high ? rdy_level : ~rdy_level;

    ebs_pkg::ebs_state_t state, next_state;
    logic [5:0]  phase_cnt, next_phase_cnt;
    logic [6:0]  unit_cnt, next_unit_cnt;
    logic [13:0] cfg, next_cfg;
    logic        wr, next_wr;
    logic [1:0]  be, next_be;
    logic [23:0] addr, next_addr;
    logic [15:0] wdat, next_wdat;
    logic [NUM_CS-1:0] cs_sel, next_cs_sel;
    logic [15:0] next_rdata;
    logic        next_done;

    logic [13:0] sel_cfg;
    assign sel_cfg = phase_cfg[req_cs*ebs_pkg::CFG_WIDTH +: ebs_pkg::CFG_WIDTH];

    function automatic logic [5:0] phase_len(input ebs_pkg::ebs_state_t s, input logic [13:0] c);
        logic [2:0] a;
        logic [5:0] e;
        a = c[ebs_pkg::CFG_ADDR_LSB +: 3];
        e = c[ebs_pkg::CFG_ACCESS_LSB +: 6];
        phase_len = 6'h00;
        case (s)
            ebs_pkg::EBS_ADDR:
                phase_len = (a == ebs_pkg::ADDR_LEN_ALT || a == ebs_pkg::ADDR_LEN_MAX) ?
                            {3'h0, a} : {3'h0, ebs_pkg::ADDR_LEN_MIN};
            ebs_pkg::EBS_SETUP:  phase_len = {4'h0, c[ebs_pkg::CFG_SETUP_LSB +: 2]};
            ebs_pkg::EBS_DELAY:  phase_len = {5'h00, c[ebs_pkg::CFG_DELAY_LSB]};
            ebs_pkg::EBS_ACCESS:
                phase_len = (e < ebs_pkg::ACCESS_LEN_MIN) ? ebs_pkg::ACCESS_LEN_MIN :
                            (e > ebs_pkg::ACCESS_LEN_MAX) ? ebs_pkg::ACCESS_LEN_MAX : e;
            ebs_pkg::EBS_RECOV:  phase_len = {4'h0, c[ebs_pkg::CFG_RECOV_LSB +: 2]};
            default:             phase_len = 6'h00;
        endcase
    endfunction

    // next nonzero phase after s, used to skip zero length phases
    function automatic ebs_pkg::ebs_state_t next_phase(input ebs_pkg::ebs_state_t s,
                                                      input logic [13:0] c);
        next_phase = ebs_pkg::EBS_IDLE;
        case (s)
            ebs_pkg::EBS_ADDR:
                next_phase = (phase_len(ebs_pkg::EBS_SETUP, c) != 6'h00) ? ebs_pkg::EBS_SETUP :
                             (phase_len(ebs_pkg::EBS_DELAY, c) != 6'h00) ? ebs_pkg::EBS_DELAY :
                             ebs_pkg::EBS_ACCESS;
            ebs_pkg::EBS_SETUP:
                next_phase = (phase_len(ebs_pkg::EBS_DELAY, c) != 6'h00) ? ebs_pkg::EBS_DELAY :
                             ebs_pkg::EBS_ACCESS;
            ebs_pkg::EBS_DELAY:  next_phase = ebs_pkg::EBS_ACCESS;
            ebs_pkg::EBS_ACCESS:
                next_phase = (phase_len(ebs_pkg::EBS_RECOV, c) != 6'h00) ? ebs_pkg::EBS_RECOV :
                             ebs_pkg::EBS_IDLE;
            default:             next_phase = ebs_pkg::EBS_IDLE;
        endcase
    endfunction

    logic unit_end;
    logic phase_end;
    logic access_hold;
    assign unit_end = (unit_cnt == 7'(UNIT_CYC - 1));
    assign phase_end = unit_end && (phase_cnt == phase_len(state, cfg) - 6'h01);
    // inactive ready at sampling point adds a waitstate
    assign access_hold = ready_en && !rdy_seen;

    always_comb begin
        next_state     = state;
        next_phase_cnt = phase_cnt;
        next_unit_cnt  = unit_cnt;
        next_cfg       = cfg;
        next_wr        = wr;
        next_be        = be;
        next_addr      = addr;
        next_wdat      = wdat;
        next_cs_sel    = cs_sel;
        next_rdata     = rdata;
        next_done      = 1'b0;
        case (state)
            ebs_pkg::EBS_IDLE: begin
                // idle unit gap
                // selects stay high one full unit between cycles
                if (!unit_end)
                    next_unit_cnt = unit_cnt + 7'h01;
                if (req && !done && unit_end) begin
                    next_state     = ebs_pkg::EBS_ADDR;
                    next_phase_cnt = 6'h00;
                    next_unit_cnt  = 7'h00;
                    next_cfg       = sel_cfg;
                    next_wr        = req_write;
                    next_be        = req_byte_en;
                    next_addr      = req_addr;
                    next_wdat      = req_wdata;
                    next_cs_sel    = NUM_CS'(1) << req_cs;
                end
            end
            ebs_pkg::EBS_ADDR, ebs_pkg::EBS_SETUP, ebs_pkg::EBS_DELAY,
            ebs_pkg::EBS_ACCESS, ebs_pkg::EBS_RECOV: begin
                // phases counted in units of at least 12.5 ns
                next_unit_cnt = unit_end ? 7'h00 : unit_cnt + 7'h01;
                if (unit_end)
                    next_phase_cnt = phase_cnt + 6'h01;
                if (phase_end && state == ebs_pkg::EBS_ACCESS && access_hold) begin
                    // waitstate of one unit then sample again
                    next_phase_cnt = phase_cnt;
                end else if (phase_end) begin
                    next_state     = next_phase(state, cfg);
                    next_phase_cnt = 6'h00;
                    // capture read data at end of access
                    if (state == ebs_pkg::EBS_ACCESS && !wr)
                        next_rdata = multiplexed_mode ? shared_addr_data_i : separate_data_i;
                    if (next_phase(state, cfg) == ebs_pkg::EBS_IDLE)
                        next_done = 1'b1;
                end
            end
            default: next_state = ebs_pkg::EBS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state     <= ebs_pkg::EBS_IDLE;
            phase_cnt <= 6'h00;
            unit_cnt  <= 7'h00;
            cfg       <= ebs_pkg::CFG_RESET;
            wr        <= 1'b0;
            be        <= 2'h0;
            addr      <= 24'h00_0000;
            wdat      <= 16'h0000;
            cs_sel    <= '0;
            rdata     <= 16'h0000;
            done      <= 1'b0;
        end else begin
            state     <= next_state;
            phase_cnt <= next_phase_cnt;
            unit_cnt  <= next_unit_cnt;
            cfg       <= next_cfg;
            wr        <= next_wr;
            be        <= next_be;
            addr      <= next_addr;
            wdat      <= next_wdat;
            cs_sel    <= next_cs_sel;
            rdata     <= next_rdata;
            done      <= next_done;
        end
    end

    // registered pin drivers
    logic in_cycle;
    logic strobe_phase;
    assign in_cycle     = (state != ebs_pkg::EBS_IDLE);
    assign strobe_phase = (state == ebs_pkg::EBS_DELAY) || (state == ebs_pkg::EBS_ACCESS);
    always_ff @(posedge clk) begin
        if (!resetn) begin
            address_lines       <= 24'h00_0000;
            shared_addr_data_o  <= 16'h0000;
            shared_addr_data_oe <= 1'b0;
            separate_data_o     <= 16'h0000;
            separate_data_oe    <= 1'b0;
            read_strobe_n       <= 1'b1;
            write_low_n         <= 1'b1;
            write_high_n        <= 1'b1;
            byte_high_enable_n  <= 1'b1;
            addr_latch          <= 1'b0;
            chip_select_n       <= '1;
        end else begin
            // demux address held until the next cycle starts, read data unaffected
            address_lines       <= next_addr;
            // mux: address in address phase, then write data
            shared_addr_data_o  <= (next_state == ebs_pkg::EBS_ADDR) ? next_addr[15:0] : next_wdat;
            shared_addr_data_oe <= multiplexed_mode && (next_state == ebs_pkg::EBS_ADDR ||
                                   (next_wr && next_state != ebs_pkg::EBS_IDLE));
            separate_data_o     <= next_wdat;
            separate_data_oe    <= !multiplexed_mode && next_wr &&
                                   next_state != ebs_pkg::EBS_IDLE;
            read_strobe_n       <= !(!next_wr && (next_state == ebs_pkg::EBS_DELAY ||
                                   next_state == ebs_pkg::EBS_ACCESS));
            write_low_n         <= !(next_wr && next_be[0] && next_state == ebs_pkg::EBS_ACCESS);
            write_high_n        <= !(next_wr && next_be[1] && next_state == ebs_pkg::EBS_ACCESS);
            byte_high_enable_n  <= !(next_state != ebs_pkg::EBS_IDLE && next_be[1]);
            // latch strobe high during address phase in mux mode
            addr_latch          <= multiplexed_mode && next_state == ebs_pkg::EBS_ADDR;
            chip_select_n       <= (next_state != ebs_pkg::EBS_IDLE) ? ~next_cs_sel : '1;
        end
    end
endmodule

/* File: ebs_pkg.sv */
// ebs_pkg: constants for the external bus cycle sequencer
// assumes a single 250 MHz system clock
package ebs_pkg;
    localparam int unsigned CLK_PERIOD_PS      = 4000;
    // least distance between bus pin transitions, in ps
    localparam int unsigned MIN_TRANS_PS       = 12500;
    localparam int unsigned MIN_TRANS_CYC      = (MIN_TRANS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // phase length limits in phase time units
    localparam logic [2:0] ADDR_LEN_MIN        = 3'h1;
    localparam logic [2:0] ADDR_LEN_MAX        = 3'h2;
    localparam logic [2:0] ADDR_LEN_ALT        = 3'h5;
    localparam logic [1:0] SETUP_LEN_MAX       = 2'h3;
    localparam logic [0:0] DELAY_LEN_MAX       = 1'h1;
    localparam logic [5:0] ACCESS_LEN_MIN      = 6'h01;
    localparam logic [5:0] ACCESS_LEN_MAX      = 6'h20;
    localparam logic [1:0] RECOV_LEN_MAX       = 2'h3;
    // phase timing config field layout, per chip select
    localparam int unsigned CFG_ADDR_LSB       = 0;
    localparam int unsigned CFG_SETUP_LSB      = 3;
    localparam int unsigned CFG_DELAY_LSB      = 5;
    localparam int unsigned CFG_ACCESS_LSB     = 6;
    localparam int unsigned CFG_RECOV_LSB      = 12;
    localparam int unsigned CFG_WIDTH          = 14;
    localparam logic [13:0] CFG_RESET          = 14'h0041;
    typedef enum logic [2:0] {
        EBS_IDLE   = 3'b000,
        EBS_ADDR   = 3'b001,
        EBS_SETUP  = 3'b010,
        EBS_DELAY  = 3'b011,
        EBS_ACCESS = 3'b100,
        EBS_RECOV  = 3'b101
    } ebs_state_t;
endpackage

/* File: ebs_asserts.sv */
// ebs_asserts: pin protocol checks for the bus cycle sequencer
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/100ps
module ebs_asserts #(
    parameter int unsigned NUM_CS = 4
) (
    input wire logic              clk,                 // system clock
    input wire logic              resetn,              // sync reset
    input wire logic              done,                // cycle finished
    input wire logic              multiplexed_mode,    // bus mode
    input wire logic              ready_en,            // ready controls access
    input wire logic              ready_active_high,   // ready polarity
    input wire logic              bus_reference_clock, // clock copy
    input wire logic              shared_addr_data_oe, // mux lines enable
    input wire logic              separate_data_oe,    // demux data enable
    input wire logic              read_strobe_n,       // read strobe
    input wire logic              write_low_n,         // low write strobe
    input wire logic              write_high_n,        // high write strobe
    input wire logic              byte_high_enable_n,  // high byte enable
    input wire logic              addr_latch,          // latch strobe
    input wire logic [NUM_CS-1:0] chip_select_n,       // selects
    input wire logic              ready_pin            // external ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_one_select: assert property ($onehot0(~chip_select_n))
        else $error("more than one select active");
    a_strobe_in_cycle: assert property (!(read_strobe_n && write_low_n && write_high_n)
        |-> !(&chip_select_n)) else $error("strobe active without a select");
    a_select_release: assert property (done |=> !done && &chip_select_n)
        else $error("select or done not released after done");
    a_latch_mux: assert property (addr_latch |-> multiplexed_mode && !(&chip_select_n)
        && read_strobe_n && write_low_n && write_high_n) else $error("latch misplaced");
    a_read_released: assert property (!read_strobe_n |-> !shared_addr_data_oe
        && !separate_data_oe) else $error("lines driven during read");
    a_write_lines: assert property (!(write_low_n && write_high_n) |-> (multiplexed_mode ?
        shared_addr_data_oe : separate_data_oe)) else $error("write data not driven");
    a_high_enable: assert property (!write_high_n |-> !byte_high_enable_n)
        else $error("high write without high enable");
    a_no_rd_wr: assert property (!(!read_strobe_n && !(write_low_n && write_high_n)))
        else $error("read and write strobes together");
    a_ready_end: assert property (ready_en && $rose(read_strobe_n && write_low_n && write_high_n)
        |-> ready_pin == ready_active_high) else $error("access ended without ready");
    a_ref_clock: assert property (bus_reference_clock == clk)
        else $error("reference clock differs from clock");
    c_mux_done: cover property (done && multiplexed_mode);
    c_ready_done: cover property (done && ready_en);
    c_high_write: cover property (!write_high_n && write_low_n);
endmodule
bind ebs_sequencer ebs_asserts #(.NUM_CS(NUM_CS)) u_asserts (.clk, .resetn, .done,
    .multiplexed_mode, .ready_en, .ready_active_high, .bus_reference_clock,
    .shared_addr_data_oe, .separate_data_oe, .read_strobe_n, .write_low_n, .write_high_n,
    .byte_high_enable_n, .addr_latch, .chip_select_n, .ready_pin);

/* File: ebs_mem_model.sv */
// ebs_mem_model: 16-word external memory with ready handshake
// assumes strobes and selects come from the sequencer on the same clock
`timescale 1ns/100ps
module ebs_mem_model (
    input  wire logic        clk,               // system clock
    input  wire logic        multiplexed_mode,  // bus mode
    input  wire logic        addr_latch,        // latch strobe
    input  wire logic [23:0] address_lines,     // demux address
    input  wire logic [15:0] wdata_mux,         // shared lines driven
    input  wire logic [15:0] wdata_demux,       // data lines driven
    input  wire logic        read_strobe_n,     // read strobe
    input  wire logic        write_low_n,       // low write strobe
    input  wire logic        write_high_n,      // high write strobe
    input  wire logic        cs_idle,           // all selects high
    input  wire logic        ready_active_high, // ready polarity
    input  wire logic [3:0]  ready_delay,       // strobe cycles before ready
    output logic      [15:0] rd_data,           // read data lines
    output logic             ready_pin          // ready output
);
    logic [15:0] mem [16];
    logic [15:0] last_q;
    logic [3:0]  idx;
    logic [3:0]  wait_cnt;
    logic        cs_idle_q;
    logic        rdy;
    // data wanders off once the read strobe is up
    assign rd_data = read_strobe_n ? ~last_q : mem[idx];
    // ready after a delay, dropped after the trailing edge
    assign ready_pin = rdy ~^ ready_active_high;
    always_ff @(posedge clk) begin
        cs_idle_q <= cs_idle;
        if (addr_latch)
            idx <= wdata_mux[4:1];
        else if (!multiplexed_mode && cs_idle_q && !cs_idle)
            idx <= address_lines[4:1];
        if (!read_strobe_n)
            last_q <= mem[idx];
        if (!write_low_n)
            mem[idx][7:0] <= multiplexed_mode ? wdata_mux[7:0] : wdata_demux[7:0];
        if (!write_high_n)
            mem[idx][15:8] <= multiplexed_mode ? wdata_mux[15:8] : wdata_demux[15:8];
        if (read_strobe_n && write_low_n && write_high_n) begin
            rdy <= 1'b0;
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == ready_delay)
                rdy <= 1'b1;
        end
    end
endmodule

/* File: ebs_tb.sv */
// tb: directed bench for the external bus cycle sequencer
// assumes the memory model answers every select and handshakes ready
`timescale 1ns/100ps
module tb;
    localparam logic [55:0] CFG = {2'h3, 6'h02, 1'h1, 2'h3, 3'h1, 2'h2, 6'h20, 1'h0, 2'h2, 3'h5,
                                   2'h1, 6'h03, 1'h1, 2'h1, 3'h2, 2'h0, 6'h01, 1'h0, 2'h0, 3'h1};
    logic clk = 1'b0, resetn = 1'b0, req = 1'b0, req_write = 1'b0, multiplexed_mode = 1'b0;
    logic ready_en = 1'b0, ready_active_high = 1'b0, ready_async = 1'b0;
    logic [1:0]  req_byte_en = 2'b11, req_cs = 2'd0;
    logic [23:0] req_addr = 24'h00_0000, address_lines, a;
    logic [15:0] req_wdata = 16'h0000, rdata, shared_addr_data_o, separate_data_o, rd_data, d;
    logic [15:0] shared_addr_data_i, separate_data_i;
    logic [3:0]  chip_select_n;
    logic done, bus_reference_clock, shared_addr_data_oe, separate_data_oe, read_strobe_n;
    logic write_low_n, write_high_n, byte_high_enable_n, addr_latch, ready_pin;
    int n_mismatch = 0, checks_done = 0, lc, lc_sync, m, c;
    int sum_q [4] = '{2, 8, 41, 10};
    assign shared_addr_data_i = shared_addr_data_oe ? shared_addr_data_o : rd_data;
    assign separate_data_i = separate_data_oe ? separate_data_o : rd_data;
    always #2 clk = ~clk;
    ebs_sequencer #(.NUM_CS(4), .UNIT_CYC(1)) u_dut (.clk, .resetn, .req, .req_write,
        .req_byte_en, .req_addr, .req_wdata, .req_cs, .done, .rdata, .phase_cfg(CFG),
        .multiplexed_mode, .ready_en, .ready_active_high, .ready_async, .bus_reference_clock,
        .address_lines, .shared_addr_data_o, .shared_addr_data_oe, .shared_addr_data_i,
        .separate_data_o, .separate_data_oe, .separate_data_i, .read_strobe_n, .write_low_n,
        .write_high_n, .byte_high_enable_n, .addr_latch, .chip_select_n, .ready_pin);
    ebs_mem_model u_mem (.clk, .multiplexed_mode, .addr_latch, .address_lines,
        .wdata_mux(shared_addr_data_o), .wdata_demux(separate_data_o), .read_strobe_n,
        .write_low_n, .write_high_n, .cs_idle(&chip_select_n), .ready_active_high,
        .ready_delay(4'h5), .rd_data, .ready_pin);
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one bus cycle; counts the cycles its select is low
    task automatic xfer(input logic w, input logic [1:0] be, input logic [23:0] ad,
                        input logic [15:0] wd, input logic [1:0] cs, output int low);
        int k;
        low = 0;
        {req, req_write, req_byte_en, req_addr, req_wdata, req_cs} = {1'b1, w, be, ad, wd, cs};
        for (k = 0; k < 400; k++) begin
            @(negedge clk);
            if (chip_select_n[cs] === 1'b0) low++;
            if (done === 1'b1) break;
        end
        req = 1'b0;
        if (k == 400) begin
            n_mismatch++;
            print_verdict();
        end
        @(negedge clk);
        if (chip_select_n[cs] === 1'b0) low++;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        chk(32'({chip_select_n, read_strobe_n, write_low_n, write_high_n, addr_latch,
            shared_addr_data_oe, separate_data_oe, done}), 32'h0000_07F0);
        resetn = 1'b1;
        @(negedge clk);
        for (m = 0; m < 2; m++) begin
            multiplexed_mode = m[0];
            for (c = 0; c < 4; c++) begin
                a = {19'h3_5A00, m[0], c[1:0], 2'b00};
                d = {12'hC3A, 1'b0, m[0], c[1:0]};
                xfer(1'b1, 2'b11, a, d, c[1:0], lc);
                chk(32'(lc), 32'(sum_q[c]));
                xfer(1'b0, 2'b11, a, 16'h0000, c[1:0], lc);
                chk(32'(lc), 32'(sum_q[c]));
                chk(32'(rdata), 32'(d));
            end
        end
        multiplexed_mode = 1'b0;
        a = 24'h6B_A000;
        xfer(1'b1, 2'b01, a, 16'h1234, 2'd0, lc);
        xfer(1'b1, 2'b10, a, 16'hAB00, 2'd0, lc);
        xfer(1'b0, 2'b11, a, 16'h0000, 2'd0, lc);
        chk(32'(rdata), 32'h0000_AB34);
        ready_en = 1'b1;
        for (m = 0; m < 4; m++) begin
            ready_active_high = m[0];
            ready_async = m[1];
            xfer(1'b0, 2'b11, a, 16'h0000, 2'd0, lc);
            chk(32'(rdata), 32'h0000_AB34);
            chk(32'(lc > 5), 32'h0000_0001);
            if (m[1])
                chk(32'(lc > lc_sync), 32'h0000_0001);
            else
                lc_sync = lc;
        end
        // mid-run reset: pins idle, read data cleared, then a ready read again
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        chk(32'({chip_select_n, read_strobe_n, addr_latch, done, rdata}), 32'h007C_0000);
        resetn = 1'b1;
        @(negedge clk);
        xfer(1'b0, 2'b11, a, 16'h0000, 2'd0, lc);
        chk(32'(rdata), 32'h0000_AB34);
        print_verdict();
    end
endmodule
